// ### rtl/ubr_defs.vh
// constants for the apb access and receiver synchronisation block
// assumes inclusion by bare name from rtl design files
`ifndef UBR_DEFS_VH
`define UBR_DEFS_VH
`define UBR_CLK_HZ 32'h01312D00
`define UBR_ADDR_DIV_LO 4'h0
`define UBR_ADDR_DIV_HI 4'h4
`define UBR_ADDR_CTRL 4'h8
`define UBR_ADDR_STAT 4'hC
`define UBR_ADDR_DATA 4'h0
`define UBR_DIV_RST 16'h0001
`define UBR_CTRL_RST 8'h03
`define UBR_TICKS_PER_BIT 5'h10
`define UBR_TICKS_FIRST 5'h18
`endif

// ### rtl/ubr_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ubr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire ref_clk,
	input wire sys_rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	reg out_full;
	wire do_wr;
	wire do_rd;
	wire [AW:0] used;
	// one word sits in the output register, the rest in mem
	assign out_valid = out_full;
	assign do_rd = (count != {(AW+1){1'b0}}) && (!out_full || out_ready);
	// fill level counts the output register too, so the fifo holds DEPTH words
	assign used = count + {{AW{1'b0}}, out_full};
	assign in_ready = (used != DEPTH[AW:0]) || (out_full && out_ready);
	assign do_wr = in_valid && in_ready;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			out_full <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (do_wr) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				out_data <= mem[rd_ptr];
				rd_ptr <= rd_ptr + 1'b1;
				out_full <= 1'b1;
			end else if (out_ready) begin
				out_full <= 1'b0;
			end
			count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
		end
	end
endmodule // ubr_fifo
`default_nettype wire

// ### rtl/ubr_uart_rx.v
// apb register access and serial receiver with start-bit synchronisation
// assumes an apb master on ref_clk and an asynchronous serial line on rx_in
`timescale 1ns/1ps
`default_nettype none
`include "ubr_defs.vh"
// Notes on behaviour
// - selected enabled write updates the addressed register on that edge
// - selected enabled read is done on that edge with the address then on paddr
// - idle receiver takes a low line as start, resyncing bit timing there
// - first data bit sampled one and a half bit periods after start edge
// - later bits sampled one bit period apart, at mid-bit
module ubr_uart_rx (
	input wire ref_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [3:0] paddr,
	input wire [7:0] pwdata,
	output reg [7:0] prdata,
	output wire pready,
	input wire rx_in,
	output wire rx_ready_n,
	output reg frame_err
);
	localparam S_IDLE = 4'h1;
	localparam S_START = 4'h2;
	localparam S_DATA = 4'h4;
	localparam S_STOP = 4'h8;

	reg [15:0] divisor;
	reg [7:0] ctrl;
	reg [15:0] div_cnt;
	reg baud_tick;
	reg rx_meta;
	reg rx_sync;
	reg [3:0] state;
	reg [4:0] tick_cnt;
	reg [2:0] bit_idx;
	reg [7:0] shift;
	reg push;
	reg [7:0] push_data;
	wire acc;
	wire wr_en;
	wire rd_en;
	wire fifo_ready;
	wire fifo_valid;
	wire [7:0] fifo_data;
	wire pop;
	wire [3:0] num_bits;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function [7:0] shift_in;
		input [7:0] word;
		input bit_val;
		begin
			shift_in = {bit_val, word[7:1]};
		end
	endfunction

	function [4:0] tick_inc;
		input [4:0] cnt;
		begin
			tick_inc = cnt + 5'h01;
		end
	endfunction

	// ---------------------------------------------------------------
	// apb access
	// ---------------------------------------------------------------
	assign pready = 1'b1;
	assign acc = psel && penable;
	assign wr_en = acc && pwrite;
	assign rd_en = acc && !pwrite;
	assign pop = rd_en && (paddr == `UBR_ADDR_DATA);

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			divisor <= `UBR_DIV_RST;
			ctrl <= `UBR_CTRL_RST;
		end else if (wr_en) begin
			case (paddr)
				`UBR_ADDR_DIV_LO: divisor[7:0] <= pwdata;
				`UBR_ADDR_DIV_HI: divisor[15:8] <= pwdata;
				`UBR_ADDR_CTRL: ctrl <= pwdata;
				default: ;
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 8'h00;
		end else if (rd_en) begin
			case (paddr)
				`UBR_ADDR_DATA: prdata <= fifo_valid ? fifo_data : 8'h00;
				`UBR_ADDR_DIV_HI: prdata <= divisor[15:8];
				`UBR_ADDR_CTRL: prdata <= ctrl;
				`UBR_ADDR_STAT: prdata <= {6'h00, frame_err, fifo_valid};
				default: prdata <= 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// baud tick divider
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			div_cnt <= 16'h0000;
			baud_tick <= 1'b0;
		end else if (div_cnt >= divisor - 16'h0001) begin
			div_cnt <= 16'h0000;
			baud_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
			baud_tick <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// receiver
	// ---------------------------------------------------------------
	assign num_bits = {2'b00, ctrl[1:0]} + 4'h5;

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rx_in;
			rx_sync <= rx_meta;
		end
	end

	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= S_IDLE;
			tick_cnt <= 5'h00;
			bit_idx <= 3'h0;
			shift <= 8'h00;
			push <= 1'b0;
			push_data <= 8'h00;
			frame_err <= 1'b0;
		end else begin
			if (push && fifo_ready)
				push <= 1'b0;
			if (rd_en && paddr == `UBR_ADDR_STAT)
				frame_err <= 1'b0;
			case (state)
				S_IDLE: begin
					// level start: a line still low after a bad stop opens a new frame
					if (!rx_sync) begin
						state <= S_START;
						tick_cnt <= 5'h00;
						bit_idx <= 3'h0;
					end
				end
				S_START: begin
					if (baud_tick) begin
						if (tick_cnt == `UBR_TICKS_FIRST - 5'h01) begin
							shift <= shift_in(shift, rx_sync);
							tick_cnt <= 5'h00;
							bit_idx <= 3'h1;
							state <= (num_bits == 4'h1) ? S_STOP : S_DATA;
						end else begin
							tick_cnt <= tick_inc(tick_cnt);
						end
					end
				end
				S_DATA: begin
					if (baud_tick) begin
						if (tick_cnt == `UBR_TICKS_PER_BIT - 5'h01) begin
							shift <= shift_in(shift, rx_sync);
							tick_cnt <= 5'h00;
							bit_idx <= bit_idx + 3'h1;
							if ({1'b0, bit_idx} == num_bits - 4'h1)
								state <= S_STOP;
						end else begin
							tick_cnt <= tick_inc(tick_cnt);
						end
					end
				end
				S_STOP: begin
					if (baud_tick) begin
						if (tick_cnt == `UBR_TICKS_PER_BIT - 5'h01) begin
							// stop bit sampled at mid-bit; shift right-aligns short words
							push <= 1'b1;
							push_data <= shift >> (4'h8 - num_bits);
							if (!rx_sync)
								frame_err <= 1'b1;
							state <= S_IDLE;
						end else begin
							tick_cnt <= tick_inc(tick_cnt);
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receive fifo
	// ---------------------------------------------------------------
	ubr_fifo #(
		.WIDTH(8),
		.DEPTH(4),
		.AW(2)
	) u_fifo (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	assign rx_ready_n = !fifo_valid;
endmodule // ubr_uart_rx
`default_nettype wire

// ### test/test_ubr_uart_rx.sv
// bench for the apb access and receiver block
// assumes line model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ubr_uart_rx;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [3:0] paddr = 4'h0;
	logic [7:0] pwdata = 8'h00;
	wire logic [7:0] prdata;
	wire logic pready, rx_ready_n, frame_err, rx_in;
	int failures = 0;
	int compares = 0;
	ubr_uart_rx dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.rx_in(rx_in), .rx_ready_n(rx_ready_n), .frame_err(frame_err));
	ubr_line_model tx (.ref_clk(ref_clk), .line(rx_in));
	initial forever #25 ref_clk = ~ref_clk;
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(negedge ref_clk);
		penable = 1'b1;
		@(negedge ref_clk);
		psel = 1'b0;
		penable = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(prdata, e);
	endtask
	task automatic wait_rx();
		for (int i = 0; i < 4000 && rx_ready_n !== 1'b0; i++)
			@(negedge ref_clk);
		if (rx_ready_n !== 1'b0) begin
			failures++;
			close_out();
		end
	endtask
	task automatic s_regs();
		rd_chk(4'h8, 8'h03);
		apb(1'b1, 4'h4, 8'h5A);
		rd_chk(4'h4, 8'h5A);
		apb(1'b1, 4'h4, 8'h00);
		rd_chk(4'h2, 8'h00);
		rd_chk(4'h0, 8'h00);
	endtask
	task automatic s_rx();
		tx.send(8'h55, 1'b1, 16);
		wait_rx();
		rd_chk(4'h0, 8'h55);
		check({7'h00, rx_ready_n}, 8'h01);
		apb(1'b1, 4'h0, 8'h02);
		tx.send(8'hA3, 1'b1, 32);
		tx.send(8'h3C, 1'b1, 32);
		rd_chk(4'h0, 8'hA3);
		rd_chk(4'h0, 8'h3C);
	endtask
	task automatic s_short();
		apb(1'b1, 4'h8, 8'h00);
		tx.send(8'hF3, 1'b1, 32);
		rd_chk(4'h0, 8'h13);
		check({7'h00, rx_ready_n}, 8'h01);
		check({7'h00, frame_err}, 8'h00);
		apb(1'b1, 4'h8, 8'h03);
		rd_chk(4'h8, 8'h03);
	endtask
	task automatic s_ferr();
		tx.send(8'h0F, 1'b0, 32);
		check({7'h00, frame_err}, 8'h01);
		apb(1'b0, 4'hC, 8'h00);
		check(prdata, 8'h03);
		check({7'h00, frame_err}, 8'h00);
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		sys_rst = 1'b0;
		s_regs();
		s_rx();
		s_short();
		s_ferr();
		close_out();
	end
endmodule // test_ubr_uart_rx
`default_nettype wire

// ### test/ubr_line_model.sv
// serial transmitter on the receiver input
// assumes bit length is given in clock cycles
`timescale 1ns/1ps
`default_nettype none
module ubr_line_model (
	input wire logic ref_clk,
	output logic line
);
	initial line = 1'b1;
	task automatic send(input logic [7:0] b, input logic stop, input int cyc);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line = f[i];
			repeat (cyc) @(negedge ref_clk);
		end
		line = 1'b1;
		// one idle cycle between frames
		@(negedge ref_clk);
	endtask
endmodule // ubr_line_model
`default_nettype wire

// ### test/ubr_uart_rx_props.sv
// checker for the apb access and receiver block
// assumes it is bound onto ubr_uart_rx
`timescale 1ns/1ps
`default_nettype none
module ubr_rx_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [3:0] paddr,
	input wire logic [7:0] pwdata,
	input wire logic [7:0] prdata,
	input wire logic pready,
	input wire logic rx_in,
	input wire logic rx_ready_n,
	input wire logic frame_err
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	wire logic rd = psel && penable && !pwrite;
	ready_high_a: assert property (pready) else $error("pready low");
	rd_hold_a: assert property (!rd |=> $stable(prdata)) else $error("prdata moved");
	pop_only_a: assert property ($rose(rx_ready_n) |-> $past(rd && paddr == 4'h0))
		else $error("byte lost");
	reset_idle_a: assert property ($fell(sys_rst) |-> prdata == 8'h00 && rx_ready_n)
		else $error("not idle");
	err_hold_a: assert property (frame_err && !(rd && paddr == 4'hC) |=> frame_err)
		else $error("error lost");
	err_cause_a: assert property ($rose(frame_err) |-> !$past(rx_in, 3) || !$past(rx_in, 4))
		else $error("error without low stop");
	cover property (rd && paddr == 4'h0);
	cover property ($rose(frame_err));
	cover property ($fell(rx_ready_n));
endmodule // ubr_rx_props
bind ubr_uart_rx ubr_rx_props props (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.rx_in(rx_in),
	.rx_ready_n(rx_ready_n),
	.frame_err(frame_err)
);
`default_nettype wire
